/* rtl/tpg_test_packet_gen.sv */
// Functional notes
// RL1: Fixed-data mode fills payload with the programmed 8-bit byte.
// RL2: Mode 00 incrementing, 01 fixed byte, upper bit set pseudo-random.
// RL3: Valid pattern bytes per packet set by 3-bit field, at most six.
// RL4: Count code sends 1 to 1000000 packets; code 111 runs continuously.
// RL5: 48-bit generator pattern held in three writable 16-bit words.
// RL6: 48-bit match value in three words compared to destination address.
// RL7: Read-only bit shows CRC error on a received packet.
// RL8: Read-only bit shows CRC error on a transmitted packet.
// RL9: Transmitted packets counted in 32 bits, read as low and high words.
// RL10: Transmitted packets with CRC error counted in 16 bits.
// RL11: Reading the three transmit words in sequence clears them.
// RL12: Received packets counted in 32 bits, read as low and high words.
// RL13: Received packets with CRC error counted in 16 bits.
// RL14: Reading the three receive words in sequence clears them.
// RL15: Busy bit high while the generator runs.
// RL16: Done bit set once all requested packets are sent.
// RL17: Sequence needs ascending reads with no other access between.
// RL18: Sequence reads return words captured at the first read.
`timescale 1ns/1ps
module tpg_test_packet_gen
   import tpg_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [7:0] genData,
   output logic genValid,
   output logic genLast,
   input wire logic genReady,
   input wire tpg_frame_evt_t txFrame,
   input wire tpg_frame_evt_t rxFrame,
   input wire logic [47:0] rxDestAddr,
   output logic daMatch,
   output logic irq
);

   // ==========================================================
   // Configuration and status storage.
   tpg_cfg_t cfg_reg;
   logic [47:0] pattern_reg;
   logic [47:0] match_reg;
   logic [1:0] crcFlags_reg;
   logic [31:0] txCount_reg;
   logic [15:0] txBad_reg;
   logic [31:0] rxCount_reg;
   logic [15:0] rxBad_reg;
   logic [47:0] txSnap_reg;
   logic [47:0] rxSnap_reg;
   logic [1:0] txSeq_reg;
   logic [1:0] rxSeq_reg;
   logic [INT_BITS-1:0] intStatus_reg;
   logic [INT_BITS-1:0] intMask_reg;
   logic done_reg;
   logic stopPending_reg;

   typedef enum logic [1:0] {
      TPG_IDLE = 2'b01,
      TPG_SEND = 2'b10
   } tpg_state_t;
   tpg_state_t state_reg;
   logic [7:0] byteIdx_reg;
   logic [19:0] sentCount_reg;

   logic [9:0] idx;
   logic setupPhase;
   logic accessDone;
   logic wrDone;
   logic rdDone;
   logic mapped;
   logic [15:0] rdValue;
   logic startPulse;
   logic stopPulse;
   logic beatTaken;
   logic frameEnd;
   logic lastFrame;
   logic [7:0] payloadByte;
   logic [INT_BITS-1:0] intEvents;
   logic [2:0] validClamped;
   logic txClear;
   logic rxClear;
   logic runEnd;

   // ==========================================================
   // Helpers.
   function automatic logic [19:0] frame_total(input logic [2:0] code);
      case (code)
         3'h0: frame_total = 20'd1;
         3'h1: frame_total = 20'd10;
         3'h2: frame_total = 20'd100;
         3'h3: frame_total = 20'd1000;
         3'h4: frame_total = 20'd10000;
         3'h5: frame_total = 20'd100000;
         default: frame_total = 20'd1000000;
      endcase
   endfunction : frame_total

   function automatic logic is_mapped(input logic [9:0] i);
      is_mapped = (i >= IDX_PAYLOAD_CFG) && (i <= IDX_INT_MASK);
   endfunction : is_mapped

   // Advances a three-word read sequence that starts at base.
   function automatic logic [1:0] seq_step(input logic [1:0] seq, input logic [9:0] i,
                                           input logic [9:0] base);
      if (i == base + {8'h00, seq} && seq != 2'h2)
         seq_step = seq + 2'h1;
      else if (i == base)
         seq_step = 2'h1;
      else
         seq_step = SEQ_IDLE;
   endfunction : seq_step

   // ==========================================================
   // APB decode.
   assign idx = paddr[11:2];
   assign setupPhase = psel && !penable;
   assign accessDone = psel && penable;
   assign mapped = is_mapped(idx) && (paddr[1:0] == 2'b00);
   assign wrDone = accessDone && pwrite && mapped;
   assign rdDone = accessDone && !pwrite && mapped;
   // Zero wait state: answer is prepared in the setup cycle.
   assign pready = 1'b1;
   // A start while busy is ignored, so the payload source is never restarted mid-frame.
   assign startPulse = wrDone && (idx == IDX_GEN_CTRL) && pwdata[CTRL_START_BIT] &&
                       (state_reg == TPG_IDLE);
   assign stopPulse = wrDone && (idx == IDX_GEN_CTRL) && pwdata[CTRL_STOP_BIT];

   always_comb
   begin
      rdValue = REG_RESET;
      case (idx)
         IDX_PAYLOAD_CFG: rdValue = cfg_reg;
         IDX_PATTERN0: rdValue = pattern_reg[15:0];
         IDX_PATTERN1: rdValue = pattern_reg[31:16];
         IDX_PATTERN2: rdValue = pattern_reg[47:32];
         IDX_MATCH0: rdValue = match_reg[15:0];
         IDX_MATCH1: rdValue = match_reg[31:16];
         IDX_MATCH2: rdValue = match_reg[47:32];
         IDX_FRAME_CHECK: rdValue = {14'h0000, crcFlags_reg};
         // RL18 snapshot words
         IDX_TX_LOW: rdValue = txCount_reg[15:0];
         IDX_TX_HIGH: rdValue = (txSeq_reg == 2'h1) ? txSnap_reg[31:16] : txCount_reg[31:16];
         IDX_TX_BAD: rdValue = (txSeq_reg == 2'h2) ? txSnap_reg[47:32] : txBad_reg;
         IDX_RX_LOW: rdValue = rxCount_reg[15:0];
         IDX_RX_HIGH: rdValue = (rxSeq_reg == 2'h1) ? rxSnap_reg[31:16] : rxCount_reg[31:16];
         IDX_RX_BAD: rdValue = (rxSeq_reg == 2'h2) ? rxSnap_reg[47:32] : rxBad_reg;
         IDX_GEN_STATUS:
         begin
            // RL15 busy bit
            rdValue[STAT_BUSY_BIT] = (state_reg == TPG_SEND);
            rdValue[STAT_DONE_BIT] = done_reg;
         end
         IDX_INT_STATUS: rdValue = {12'h000, intStatus_reg};
         IDX_INT_MASK: rdValue = {12'h000, intMask_reg};
         default: rdValue = REG_RESET;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else if (setupPhase)
      begin
         prdata <= {16'h0000, rdValue};
         pslverr <= !(is_mapped(paddr[11:2]) && (paddr[1:0] == 2'b00));
      end
   end

   // ==========================================================
   // Writable configuration.
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         cfg_reg <= REG_RESET;
         pattern_reg <= {3{REG_RESET}};
         match_reg <= {3{REG_RESET}};
         intMask_reg <= INT_RESET;
      end
      else if (wrDone)
      begin
         case (idx)
            IDX_PAYLOAD_CFG: cfg_reg <= pwdata[15:0];
            // RL5 pattern words
            IDX_PATTERN0: pattern_reg[15:0] <= pwdata[15:0];
            IDX_PATTERN1: pattern_reg[31:16] <= pwdata[15:0];
            IDX_PATTERN2: pattern_reg[47:32] <= pwdata[15:0];
            // RL6 match words
            IDX_MATCH0: match_reg[15:0] <= pwdata[15:0];
            IDX_MATCH1: match_reg[31:16] <= pwdata[15:0];
            IDX_MATCH2: match_reg[47:32] <= pwdata[15:0];
            IDX_INT_MASK: intMask_reg <= pwdata[INT_BITS-1:0];
            default: ;
         endcase
      end
   end

   // RL6 address compare
   assign daMatch = (rxDestAddr == match_reg);

   // ==========================================================
   // CRC status follows the latest packet on each side.
   always_ff @(posedge mclk)
   begin
      if (!resetn)
         crcFlags_reg <= 2'b00;
      else
      begin
         // RL7 receive CRC flag
         if (rxFrame.done)
            crcFlags_reg[CRC_RX_BIT] <= rxFrame.bad;
         // RL8 transmit CRC flag
         if (txFrame.done)
            crcFlags_reg[CRC_TX_BIT] <= txFrame.bad;
      end
   end

   // ==========================================================
   // Read sequences and clear-on-sequence counters.
   // RL17 sequence tracking
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         txSeq_reg <= SEQ_IDLE;
         rxSeq_reg <= SEQ_IDLE;
      end
      else if (accessDone)
      begin
         txSeq_reg <= pwrite ? SEQ_IDLE : seq_step(txSeq_reg, idx, IDX_TX_LOW);
         rxSeq_reg <= pwrite ? SEQ_IDLE : seq_step(rxSeq_reg, idx, IDX_RX_LOW);
      end
   end

   // RL11 transmit clear
   assign txClear = rdDone && (idx == IDX_TX_BAD) && (txSeq_reg == 2'h2);
   // RL14 receive clear
   assign rxClear = rdDone && (idx == IDX_RX_BAD) && (rxSeq_reg == 2'h2);

   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         txSnap_reg <= 48'h000000000000;
         rxSnap_reg <= 48'h000000000000;
      end
      else
      begin
         // RL18 capture at first read
         // Taken on the edge that loads the low word, so a carry cannot split the halves.
         if (setupPhase && !pwrite && mapped && idx == IDX_TX_LOW)
            txSnap_reg <= {txBad_reg, txCount_reg};
         if (setupPhase && !pwrite && mapped && idx == IDX_RX_LOW)
            rxSnap_reg <= {rxBad_reg, rxCount_reg};
      end
   end

   // A packet that ends in the clearing cycle is kept as the first new count.
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         txCount_reg <= 32'h00000000;
         txBad_reg <= 16'h0000;
      end
      else if (txClear)
      begin
         txCount_reg <= {31'h00000000, txFrame.done};
         txBad_reg <= {15'h0000, txFrame.done && txFrame.bad};
      end
      else if (txFrame.done)
      begin
         // RL9 transmit count
         txCount_reg <= txCount_reg + 32'h00000001;
         // RL10 transmit error count
         if (txFrame.bad)
            txBad_reg <= txBad_reg + 16'h0001;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         rxCount_reg <= 32'h00000000;
         rxBad_reg <= 16'h0000;
      end
      else if (rxClear)
      begin
         rxCount_reg <= {31'h00000000, rxFrame.done};
         rxBad_reg <= {15'h0000, rxFrame.done && rxFrame.bad};
      end
      else if (rxFrame.done)
      begin
         // RL12 receive count
         rxCount_reg <= rxCount_reg + 32'h00000001;
         // RL13 receive error count
         if (rxFrame.bad)
            rxBad_reg <= rxBad_reg + 16'h0001;
      end
   end

   // ==========================================================
   // Packet generator.
   // RL3 clamp to six
   assign validClamped = (cfg_reg.validBytes > MAX_VALID_BYTES) ? MAX_VALID_BYTES :
                         cfg_reg.validBytes;
   assign beatTaken = genValid && genReady;
   assign frameEnd = beatTaken && genLast;
   // RL4 packet total
   assign lastFrame = (cfg_reg.countCode != COUNT_CONTINUOUS) &&
                      (sentCount_reg + 20'd1 == frame_total(cfg_reg.countCode));
   // A stopped run ends after the frame in flight and reports done like a counted one.
   assign runEnd = frameEnd && (lastFrame || stopPending_reg || stopPulse);

   // The stop write is a single pulse, so it is held until the frame in flight ends.
   always_ff @(posedge mclk)
   begin
      if (!resetn || state_reg != TPG_SEND)
         stopPending_reg <= 1'b0;
      else if (stopPulse)
         stopPending_reg <= 1'b1;
   end

   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         state_reg <= TPG_IDLE;
         byteIdx_reg <= 8'h00;
         sentCount_reg <= 20'd0;
      end
      else
      begin
         case (state_reg)
            TPG_IDLE:
               if (startPulse)
               begin
                  state_reg <= TPG_SEND;
                  byteIdx_reg <= 8'h00;
                  sentCount_reg <= 20'd0;
               end
            TPG_SEND:
               // Stop only between packets so no frame is cut short.
               if (frameEnd)
               begin
                  byteIdx_reg <= 8'h00;
                  sentCount_reg <= sentCount_reg + 20'd1;
                  if (runEnd)
                     state_reg <= TPG_IDLE;
               end
               else if (beatTaken)
                  byteIdx_reg <= byteIdx_reg + 8'h01;
            default: state_reg <= TPG_IDLE;
         endcase
      end
   end

   // RL16 done flag
   always_ff @(posedge mclk)
   begin
      if (!resetn || startPulse)
         done_reg <= 1'b0;
      else if (state_reg == TPG_SEND && runEnd)
         done_reg <= 1'b1;
   end

   tpg_payload_src u_payload
   (
      .mclk(mclk),
      .resetn(resetn),
      .mode(cfg_reg.mode),
      .fixedByte(cfg_reg.fixedByte),
      .restart(startPulse),
      .advance(beatTaken && (byteIdx_reg >= {5'h00, validClamped})),
      .payloadByte(payloadByte)
   );

   // RL3 pattern bytes first
   always_comb
   begin
      genData = payloadByte;
      if (byteIdx_reg < {5'h00, validClamped})
         genData = pattern_reg[byteIdx_reg[2:0]*8 +: 8];
   end
   assign genValid = (state_reg == TPG_SEND);
   assign genLast = genValid && (byteIdx_reg == GEN_FRAME_BYTES - 8'h01);

   // ==========================================================
   // Interrupts: new events win over a write-one clear.
   assign intEvents = {rxFrame.done && daMatch,
                       state_reg == TPG_SEND && runEnd,
                       rxFrame.done && rxFrame.bad,
                       txFrame.done && txFrame.bad};

   always_ff @(posedge mclk)
   begin
      if (!resetn)
         intStatus_reg <= INT_RESET;
      else if (wrDone && idx == IDX_INT_STATUS)
         intStatus_reg <= (intStatus_reg & ~pwdata[INT_BITS-1:0]) | intEvents;
      else
         intStatus_reg <= intStatus_reg | intEvents;
   end

   assign irq = |(intStatus_reg & intMask_reg);

endmodule : tpg_test_packet_gen

/* rtl/tpg_pkg.sv */
package tpg_pkg;

   // ==========================================================
   // Register indices; byte address is four times the index.
   localparam logic [9:0] IDX_PAYLOAD_CFG = 10'h123;
   localparam logic [9:0] IDX_PATTERN0 = 10'h124;
   localparam logic [9:0] IDX_PATTERN1 = 10'h125;
   localparam logic [9:0] IDX_PATTERN2 = 10'h126;
   localparam logic [9:0] IDX_MATCH0 = 10'h127;
   localparam logic [9:0] IDX_MATCH1 = 10'h128;
   localparam logic [9:0] IDX_MATCH2 = 10'h129;
   localparam logic [9:0] IDX_FRAME_CHECK = 10'h12a;
   localparam logic [9:0] IDX_TX_LOW = 10'h12b;
   localparam logic [9:0] IDX_TX_HIGH = 10'h12c;
   localparam logic [9:0] IDX_TX_BAD = 10'h12d;
   localparam logic [9:0] IDX_RX_LOW = 10'h12e;
   localparam logic [9:0] IDX_RX_HIGH = 10'h12f;
   localparam logic [9:0] IDX_RX_BAD = 10'h130;
   localparam logic [9:0] IDX_GEN_CTRL = 10'h131;
   localparam logic [9:0] IDX_GEN_STATUS = 10'h132;
   localparam logic [9:0] IDX_INT_STATUS = 10'h133;
   localparam logic [9:0] IDX_INT_MASK = 10'h134;

   // ==========================================================
   // Field positions and values.
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_STOP_BIT = 1;
   localparam int STAT_BUSY_BIT = 11;
   localparam int STAT_DONE_BIT = 12;
   localparam int CRC_RX_BIT = 1;
   localparam int CRC_TX_BIT = 0;
   localparam int INT_TX_BAD_BIT = 0;
   localparam int INT_RX_BAD_BIT = 1;
   localparam int INT_GEN_DONE_BIT = 2;
   localparam int INT_DA_MATCH_BIT = 3;
   localparam int INT_BITS = 4;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [3:0] INT_RESET = 4'h0;
   localparam logic [1:0] MODE_INCR = 2'b00;
   localparam logic [1:0] MODE_FIXED = 2'b01;
   localparam logic [2:0] MAX_VALID_BYTES = 3'h6;
   localparam logic [2:0] COUNT_CONTINUOUS = 3'h7;
   localparam logic [7:0] PRBS_SEED = 8'hff;
   localparam logic [7:0] PRBS_TAPS = 8'hb8;
   localparam logic [7:0] GEN_FRAME_BYTES = 8'h40;
   localparam logic [1:0] SEQ_IDLE = 2'h0;

   // ==========================================================
   // Carriers.
   typedef struct packed {
      logic [7:0] fixedByte;
      logic [1:0] mode;
      logic [2:0] validBytes;
      logic [2:0] countCode;
   } tpg_cfg_t;

   typedef struct packed {
      logic done;
      logic bad;
   } tpg_frame_evt_t;

endpackage : tpg_pkg

/* rtl/tpg_payload_src.sv */
`timescale 1ns/1ps
module tpg_payload_src
   import tpg_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [1:0] mode,
   input wire logic [7:0] fixedByte,
   input wire logic restart,
   input wire logic advance,
   output logic [7:0] payloadByte
);

   logic [7:0] incrReg;
   logic [7:0] lfsrReg;
   logic [7:0] lfsrNext;
   logic [7:0] incrNext;

   always_comb
   begin
      lfsrNext = lfsrReg[0] ? ((lfsrReg >> 1) ^ PRBS_TAPS) : (lfsrReg >> 1);
      incrNext = incrReg + 8'h01;
   end

   always_ff @(posedge mclk)
   begin
      if (!resetn || restart)
      begin
         incrReg <= 8'h00;
         lfsrReg <= PRBS_SEED;
      end
      else if (advance)
      begin
         incrReg <= incrNext;
         lfsrReg <= lfsrNext;
      end
   end

   // RL2 mode select
   always_ff @(posedge mclk)
   begin
      if (!resetn)
         payloadByte <= 8'h00;
      else if (mode == MODE_INCR)
         payloadByte <= (restart ? 8'h00 : (advance ? incrNext : incrReg));
      else if (mode == MODE_FIXED)
         // RL1 fixed byte
         payloadByte <= fixedByte;
      else
         payloadByte <= (restart ? PRBS_SEED : (advance ? lfsrNext : lfsrReg));
   end

endmodule : tpg_payload_src

/* verification/tpg_mac_model.sv */
`timescale 1ns/1ps
module tpg_mac_model
   import tpg_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic genValid,
   input wire logic genLast,
   input wire logic slow,
   input wire logic markBad,
   output logic genReady,
   output tpg_frame_evt_t txFrame
);
   logic phase_reg;

   // A slow partner takes every other beat, so stalls land inside frames.
   always_ff @(posedge mclk)
   begin
      if (!resetn)
         phase_reg <= 1'b0;
      else
         phase_reg <= !phase_reg;
   end

   assign genReady = !slow || phase_reg;

   always_ff @(posedge mclk)
   begin
      if (!resetn)
         txFrame <= '0;
      else
         txFrame <= {genValid && genReady && genLast, markBad};
   end
endmodule : tpg_mac_model

/* verification/tpg_test_packet_gen_monitor.sv */
`timescale 1ns/1ps
module tpg_test_packet_gen_monitor
   import tpg_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [7:0] genData,
   input wire logic genValid,
   input wire logic genLast,
   input wire logic genReady
);
   logic [7:0] beatCnt_reg;
   logic mapped;

   assign mapped = paddr[1:0] == 2'b00 && paddr[11:2] >= IDX_PAYLOAD_CFG
      && paddr[11:2] <= IDX_INT_MASK;

   always_ff @(posedge mclk)
   begin
      if (!resetn)
         beatCnt_reg <= 8'h00;
      else if (genValid && genReady)
         beatCnt_reg <= genLast ? 8'h00 : beatCnt_reg + 8'h01;
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   // ==========================================================
   // Register bus.
   access_ready_a: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   bad_addr_a: assert property (psel && !penable && !mapped |=> pslverr)
      else $error("unmapped access not refused");
   good_addr_a: assert property (psel && !penable && mapped |=> !pslverr)
      else $error("mapped access refused");
   upper_zero_a: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");

   // ==========================================================
   // Generator stream.
   beat_hold_a: assert property (genValid && !genReady |=> genValid && $stable(genData)
      && $stable(genLast))
      else $error("stalled beat changed");
   last_pos_a: assert property (genValid && genLast |-> beatCnt_reg == 8'h3f)
      else $error("frame end at wrong beat");
   last_due_a: assert property (genValid && beatCnt_reg == 8'h3f |-> genLast)
      else $error("frame end missing");
   start_cause_a: assert property ($rose(genValid) |-> $past(psel && penable && pwrite
      && paddr[11:2] == IDX_GEN_CTRL && pwdata[CTRL_START_BIT]))
      else $error("generator started without start write");

   cover property (genValid && genLast && genReady);
   cover property (genValid && !genReady);
   cover property (psel && penable && pslverr);
endmodule : tpg_test_packet_gen_monitor

bind tpg_test_packet_gen tpg_test_packet_gen_monitor mon (.mclk(mclk), .resetn(resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .genData(genData),
   .genValid(genValid), .genLast(genLast), .genReady(genReady));

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import tpg_pkg::*;
();
   typedef struct packed {logic [9:0] idx; logic [15:0] d; logic [15:0] e; logic err;} tpg_row_t;
   typedef struct packed {logic [1:0] m; logic [2:0] vb; logic [2:0] c; logic sl; logic bd;
      logic [7:0] n;} tpg_gen_t;
   logic mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, markBad = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, genValid, genLast, genReady, daMatch, irq, er;
   logic [7:0] genData;
   logic [47:0] rxDestAddr = '0;
   tpg_frame_evt_t txFrame, rxFrame = '0;
   int n_mismatch = 0, checked = 0;
   logic [7:0] beats[$];
   tpg_row_t rows[12] = '{'{IDX_PAYLOAD_CFG, 16'hffff, 16'hffff, 1'b0},
      '{IDX_PATTERN0, 16'h2211, 16'h2211, 1'b0}, '{IDX_PATTERN1, 16'h4433, 16'h4433, 1'b0},
      '{IDX_PATTERN2, 16'h6655, 16'h6655, 1'b0}, '{IDX_MATCH0, 16'hbeef, 16'hbeef, 1'b0},
      '{IDX_MATCH1, 16'hcafe, 16'hcafe, 1'b0}, '{IDX_MATCH2, 16'h0123, 16'h0123, 1'b0},
      '{IDX_FRAME_CHECK, 16'hffff, 16'h0000, 1'b0}, '{IDX_TX_LOW, 16'hffff, 16'h0000, 1'b0},
      '{IDX_GEN_CTRL, 16'h0002, 16'h0000, 1'b0}, '{10'h122, 16'h1234, 16'h0000, 1'b1},
      '{10'h135, 16'h1234, 16'h0000, 1'b1}};
   tpg_gen_t gens[5] = '{'{2'b00, 3'h2, 3'h0, 1'b0, 1'b0, 8'h01},
      '{2'b01, 3'h6, 3'h1, 1'b0, 1'b1, 8'h0a}, '{2'b10, 3'h7, 3'h0, 1'b1, 1'b0, 8'h01},
      '{2'b11, 3'h0, 3'h0, 1'b0, 1'b0, 8'h01}, '{2'b00, 3'h3, 3'h2, 1'b1, 1'b1, 8'h64}};

   always #25 mclk = !mclk;

   always @(posedge mclk)
      if (genValid === 1'b1 && genReady === 1'b1)
         beats.push_back(genData);

   tpg_test_packet_gen uut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .genData(genData), .genValid(genValid), .genLast(genLast),
      .genReady(genReady), .txFrame(txFrame), .rxFrame(rxFrame), .rxDestAddr(rxDestAddr),
      .daMatch(daMatch), .irq(irq));
   tpg_mac_model partner (.mclk(mclk), .resetn(resetn), .genValid(genValid),
      .genLast(genLast), .slow(slow), .markBad(markBad), .genReady(genReady), .txFrame(txFrame));

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [9:0] idx, input logic [15:0] wd);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {16'h0000, wd};
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1)
         @(posedge mclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 16'h0000);
      chk(rd, exp);
   endtask : rdchk

   task automatic wait_done();
      int n;
      n = 0;
      rd = '0;
      while (rd[STAT_DONE_BIT] !== 1'b1 && n < 20000)
      begin
         apb(1'b0, IDX_GEN_STATUS, 16'h0000);
         n++;
      end
   endtask : wait_done

   task automatic rxf(input logic bad, input logic [47:0] da);
      @(posedge mclk);
      rxFrame <= {1'b1, bad};
      rxDestAddr <= da;
      @(posedge mclk);
      rxFrame <= '0;
   endtask : rxf

   initial
   begin
      int vbc;
      logic [7:0] e;
      repeat (3) @(posedge mclk);
      chk(prdata, 32'h0);
      chk(32'(genValid), 32'h0);
      chk(32'(irq), 32'h0);
      resetn <= 1'b1;
      for (int i = 'h123; i <= 'h134; i++)
         rdchk(10'(i), 32'h0);
      foreach (rows[i])
      begin
         apb(1'b1, rows[i].idx, rows[i].d);
         chk(32'(er), 32'(rows[i].err));
         rdchk(rows[i].idx, 32'(rows[i].e));
         chk(32'(er), 32'(rows[i].err));
      end
      apb(1'b1, IDX_INT_MASK, 16'h0000);
      foreach (gens[g])
      begin
         slow <= gens[g].sl;
         markBad <= gens[g].bd;
         apb(1'b1, IDX_PAYLOAD_CFG, {8'hc3, gens[g].m, gens[g].vb, gens[g].c});
         beats.delete();
         apb(1'b1, IDX_GEN_CTRL, 16'h0001);
         rdchk(IDX_GEN_STATUS, 32'h0800);
         wait_done();
         chk(rd, 32'h1000);
         chk(32'(beats.size()), 32'(gens[g].n) * 64);
         vbc = gens[g].vb > 3'h6 ? 6 : int'(gens[g].vb);
         for (int i = 0; i < 64; i++)
         begin
            e = i < vbc ? 8'(48'h665544332211 >> (8 * i)) : gens[g].m == 2'b00 ? 8'(i - vbc)
               : gens[g].m == 2'b01 ? 8'hc3 : 8'hff;
            if (!gens[g].m[1] || i <= vbc)
               chk(32'(beats[i]), 32'(e));
         end
         rdchk(IDX_TX_LOW, 32'(gens[g].n));
         rdchk(IDX_TX_HIGH, 32'h0);
         rdchk(IDX_TX_BAD, gens[g].bd ? 32'(gens[g].n) : 32'h0);
         rdchk(IDX_TX_LOW, 32'h0);
         rdchk(IDX_FRAME_CHECK, 32'(gens[g].bd));
      end
      slow <= 1'b0;
      markBad <= 1'b0;
      apb(1'b1, IDX_PAYLOAD_CFG, 16'h0007);
      beats.delete();
      apb(1'b1, IDX_GEN_CTRL, 16'h0001);
      repeat (100) @(posedge mclk);
      apb(1'b1, IDX_GEN_CTRL, 16'h0002);
      wait_done();
      chk(32'(beats.size() % 64), 32'h0);
      chk(32'(beats.size() > 64), 32'h1);
      apb(1'b1, IDX_INT_STATUS, 16'h000f);
      rxf(1'b0, 48'h0123cafebeef);
      chk(32'(daMatch), 32'h1);
      rxf(1'b1, 48'h0123cafebeee);
      chk(32'(daMatch), 32'h0);
      rdchk(IDX_FRAME_CHECK, 32'h2);
      rdchk(IDX_INT_STATUS, 32'ha);
      chk(32'(irq), 32'h0);
      apb(1'b1, IDX_INT_MASK, 16'h0002);
      @(posedge mclk);
      chk(32'(irq), 32'h1);
      apb(1'b1, IDX_INT_STATUS, 16'h0002);
      @(posedge mclk);
      chk(32'(irq), 32'h0);
      rdchk(IDX_RX_LOW, 32'h2);
      rdchk(IDX_PAYLOAD_CFG, 32'h7);
      rdchk(IDX_RX_HIGH, 32'h0);
      rdchk(IDX_RX_BAD, 32'h1);
      rdchk(IDX_RX_LOW, 32'h2);
      rxf(1'b1, 48'h0);
      rdchk(IDX_RX_HIGH, 32'h0);
      rdchk(IDX_RX_BAD, 32'h1);
      rdchk(IDX_RX_LOW, 32'h0);
      close_out();
   end

   initial
   begin
      #(50 * 60000);
      n_mismatch++;
      close_out();
   end
endmodule : tb_top
